// ---- design/lgp_pin_sync.sv ----
`default_nettype none

module lgp_pin_sync (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [lgp_pkg::SHARED_PINS-1:0] pin_raw_i,
	output logic [lgp_pkg::SHARED_PINS-1:0] level_o,
	output logic [lgp_pkg::SHARED_PINS-1:0] change_o
);
	import lgp_pkg::*;

	logic [SHARED_PINS-1:0] meta_r;
	logic [SHARED_PINS-1:0] sync_r;
	logic [SHARED_PINS-1:0] last_r;

	// ------------------------------------------------------------
	// per-pin two-stage synchroniser and change detect
	// ------------------------------------------------------------
	for (genvar g = 0; g < SHARED_PINS; g++) begin : g_pin
		always_ff @(posedge clk_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				// start at the idle level so leaving reset makes no false edge
				meta_r[g] <= SYNC_IDLE_LEVEL[g];
				sync_r[g] <= SYNC_IDLE_LEVEL[g];
				last_r[g] <= SYNC_IDLE_LEVEL[g];
			end else begin
				meta_r[g] <= pin_raw_i[g];
				sync_r[g] <= meta_r[g];
				last_r[g] <= sync_r[g];
			end
		end
		assign change_o[g] = sync_r[g] ^ last_r[g];
	end

	assign level_o = last_r;

endmodule // lgp_pin_sync

`default_nettype wire

// ---- design/lgp_pkg.sv ----
`default_nettype none

package lgp_pkg;

	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int unsigned SHARED_PINS = 8;
	localparam int unsigned LED_COUNT = 11;
	localparam int unsigned HIGH_LEDS = 3;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_RAMP_DONE_HIGH = 8'h61;
	localparam logic [7:0] OFS_PIN_DIRECTION_SELECT = 8'h70;
	localparam logic [7:0] OFS_PIN_OUTPUT_KIND = 8'h71;
	localparam logic [7:0] OFS_PIN_LEVEL_READBACK = 8'h72;
	localparam logic [7:0] OFS_LED_ACTUATE_LOW = 8'h73;
	localparam logic [7:0] OFS_LED_ACTUATE_HIGH = 8'h74;

	// ------------------------------------------------------------
	// reset values and field masks
	// ------------------------------------------------------------
	localparam logic [7:0] RST_PIN_DIRECTION_SELECT = 8'h00;
	localparam logic [7:0] RST_PIN_OUTPUT_KIND = 8'h00;
	localparam logic [7:0] RST_PIN_LEVEL_READBACK = 8'h00;
	localparam logic [7:0] RST_LED_ACTUATE_LOW = 8'h00;
	localparam logic [7:0] RST_LED_ACTUATE_HIGH = 8'h00;
	localparam logic [7:0] RST_RAMP_DONE_HIGH = 8'h00;
	localparam logic [7:0] RST_PIN_CHANGE = 8'h00;
	// pins idle high through their pull-ups
	localparam logic [7:0] SYNC_IDLE_LEVEL = 8'hFF;
	localparam logic [7:0] READ_IDLE = 8'h00;
	localparam logic [2:0] HIGH_FIELD_RESET = 3'h0;

	// bit positions of the three high LEDs in the second actuation register
	localparam int unsigned POS_LED9 = 0;
	localparam int unsigned POS_LED10 = 1;
	localparam int unsigned POS_LED11 = 2;

	// LED index (zero based) in the eleven-wide vectors
	localparam int unsigned IDX_LED8 = 7;
	localparam int unsigned IDX_LED9 = 8;
	localparam int unsigned IDX_LED10 = 9;
	localparam int unsigned IDX_LED11 = 10;

	// ------------------------------------------------------------
	// read path states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		RD_IDLE = 2'b01,
		RD_HOLD = 2'b10
	} lgp_rd_state_t;

endpackage : lgp_pkg

`default_nettype wire

// ---- design/lgp_top.sv ----
// Function
// - ramp-done bits 2,1,0 set when LED11, LED10, LED9 finish ramping
// - direction bit 0 (reset) makes pin an input, 1 an output
// - direction bit 7 is shared pin eight, down to bit 0 pin one
// - open-drain type (reset): active value pulls low, inactive releases to high-Z
// - push-pull type drives high for logic 1 and low for logic 0
// - output type matters only for output pins, one type bit per pin
// - readback register shows level of eight pins, bit 7 pin eight, read-only
// - readback follows every pin change, whatever the pin direction
// - an input pin that changes level sets its change flag
// - change flag together with its enable asserts the interrupt
// - actuation bits act only on outputs, drive from type and polarity
// - polarity gives idle state, actuated state follows behaviour waveform
// - actuation 0 is idle or minimum duty, 1 is actuated or maximum duty
// - LED8 and LED11 ignore touch sensors, follow only actuation bits
// - LED10 linked to the group links LED9 to the group too
// - second actuation register holds LED11..9 at bits 2..0, upper bits unused
// - ramp-done bits clear on interrupt flag clear or deep sleep entry
// - polarity 0 drives actuated pin to 0, polarity 1 to 1 or high-Z
// - a linked sensor touch acts like the actuation bit set to 1, except on LED8 and LED11, which ignore it, and LED10, which takes only the group touch
`default_nettype none

module lgp_top (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [lgp_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [lgp_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_rd_i,
	output logic [lgp_pkg::DATA_W-1:0] reg_rdata_o,
	output logic reg_rvalid_o,
	input wire logic [lgp_pkg::LED_COUNT-1:0] drive_polarity_bit_i,
	input wire logic [lgp_pkg::LED_COUNT-1:0] behaviour_select_i,
	input wire logic [lgp_pkg::LED_COUNT-1:0] sensor_link_en_i,
	input wire logic [lgp_pkg::LED_COUNT-1:0] sensor_touch_i,
	input wire logic group_link_led10_i,
	input wire logic group_touch_i,
	input wire logic [lgp_pkg::HIGH_LEDS-1:0] ramp_finish_i,
	input wire logic int_flag_clear_i,
	input wire logic deep_sleep_request_i,
	input wire logic [lgp_pkg::SHARED_PINS-1:0] pin_change_clear_i,
	input wire logic [lgp_pkg::SHARED_PINS-1:0] pin_int_enable_i,
	output logic [lgp_pkg::SHARED_PINS-1:0] pin_change_flag_o,
	output logic pin_int_o,
	output logic [lgp_pkg::HIGH_LEDS-1:0] ramp_done_flag_o,
	input wire logic [lgp_pkg::SHARED_PINS-1:0] pin_i,
	output logic [lgp_pkg::LED_COUNT-1:0] pin_o,
	output logic [lgp_pkg::LED_COUNT-1:0] pin_oe_o
);
	import lgp_pkg::*;

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic [SHARED_PINS-1:0] pin_direction_bit_r;
	logic [SHARED_PINS-1:0] output_kind_bit_r;
	logic [SHARED_PINS-1:0] pin_level_bit_r;
	logic [SHARED_PINS-1:0] led_actuate_low_r;
	logic [HIGH_LEDS-1:0] led_actuate_high_r;
	logic [HIGH_LEDS-1:0] ramp_done_flag_r;
	logic [SHARED_PINS-1:0] pin_change_flag_r;
	logic pin_int_r;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;
	lgp_rd_state_t rd_state_r;
	lgp_rd_state_t rd_state_nxt;
	logic [SHARED_PINS-1:0] sync_level;
	logic [SHARED_PINS-1:0] sync_change;
	logic [LED_COUNT-1:0] led_actuate_bit;
	logic [LED_COUNT-1:0] touch_link;
	logic [LED_COUNT-1:0] effective_actuate;
	logic [LED_COUNT-1:0] led_on;
	logic [LED_COUNT-1:0] pin_value;
	logic [LED_COUNT-1:0] is_output;
	logic [LED_COUNT-1:0] is_push_pull;
	logic [LED_COUNT-1:0] pin_nxt;
	logic [LED_COUNT-1:0] pin_oe_nxt;
	logic wr_dir;
	logic wr_kind;
	logic wr_act_low;
	logic wr_act_high;
	logic ramp_clear;

	// ------------------------------------------------------------
	// write decode
	// ------------------------------------------------------------
	// writes to the readback and status offsets match nothing and are dropped
	assign wr_dir = reg_wr_i && (reg_addr_i == OFS_PIN_DIRECTION_SELECT);
	assign wr_kind = reg_wr_i && (reg_addr_i == OFS_PIN_OUTPUT_KIND);
	assign wr_act_low = reg_wr_i && (reg_addr_i == OFS_LED_ACTUATE_LOW);
	assign wr_act_high = reg_wr_i && (reg_addr_i == OFS_LED_ACTUATE_HIGH);

	// ------------------------------------------------------------
	// direction register
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pin_direction_bit_r <= RST_PIN_DIRECTION_SELECT;
		end else if (wr_dir) begin
			pin_direction_bit_r <= reg_wdata_i;
		end
	end

	// ------------------------------------------------------------
	// output type register
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			output_kind_bit_r <= RST_PIN_OUTPUT_KIND;
		end else if (wr_kind) begin
			output_kind_bit_r <= reg_wdata_i;
		end
	end

	// ------------------------------------------------------------
	// actuation registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			led_actuate_low_r <= RST_LED_ACTUATE_LOW;
		end else if (wr_act_low) begin
			led_actuate_low_r <= reg_wdata_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			led_actuate_high_r <= HIGH_FIELD_RESET;
		end else if (wr_act_high) begin
			led_actuate_high_r <= reg_wdata_i[HIGH_LEDS-1:0];
		end
	end

	// ------------------------------------------------------------
	// pin input synchroniser
	// ------------------------------------------------------------
	lgp_pin_sync u_sync (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.pin_raw_i(pin_i),
		.level_o(sync_level),
		.change_o(sync_change)
	);

	// ------------------------------------------------------------
	// level readback
	// ------------------------------------------------------------
	// fed from the history stage, so it updates one cycle after the matching change flag sets
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pin_level_bit_r <= RST_PIN_LEVEL_READBACK;
		end else begin
			pin_level_bit_r <= sync_level;
		end
	end

	// ------------------------------------------------------------
	// change flags and interrupt
	// ------------------------------------------------------------
	// a change in the clearing cycle keeps the flag set
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pin_change_flag_r <= RST_PIN_CHANGE;
		end else begin
			pin_change_flag_r <= (pin_change_flag_r & ~pin_change_clear_i)
				| (sync_change & ~pin_direction_bit_r);
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pin_int_r <= 1'b0;
		end else begin
			pin_int_r <= |(pin_change_flag_r & pin_int_enable_i);
		end
	end

	// ------------------------------------------------------------
	// ramp-done status
	// ------------------------------------------------------------
	assign ramp_clear = int_flag_clear_i || deep_sleep_request_i;

	// a finish in the clearing cycle keeps its bit set
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ramp_done_flag_r <= HIGH_FIELD_RESET;
		end else begin
			ramp_done_flag_r <= (ramp_clear ? HIGH_FIELD_RESET : ramp_done_flag_r)
				| ramp_finish_i;
		end
	end

	// ------------------------------------------------------------
	// actuation with sensor linking
	// ------------------------------------------------------------
	assign led_actuate_bit = {led_actuate_high_r, led_actuate_low_r};

	always_comb begin
		touch_link = sensor_link_en_i & sensor_touch_i;
		// group link on LED10 pulls LED9 into the group
		touch_link[IDX_LED10] = group_link_led10_i && group_touch_i;
		touch_link[IDX_LED9] = (sensor_link_en_i[IDX_LED9] && sensor_touch_i[IDX_LED9])
			|| (group_link_led10_i && group_touch_i);
		touch_link[IDX_LED8] = 1'b0;
		touch_link[IDX_LED11] = 1'b0;
	end

	assign effective_actuate = led_actuate_bit | touch_link;

	// ------------------------------------------------------------
	// pin drive
	// ------------------------------------------------------------
	// the three high LEDs have no shared function: always open-drain outputs
	assign is_output = {{HIGH_LEDS{1'b1}}, pin_direction_bit_r};
	assign is_push_pull = {{HIGH_LEDS{1'b0}}, output_kind_bit_r};

	for (genvar g = 0; g < LED_COUNT; g++) begin : g_drive
		// actuated phase follows the behaviour waveform, idle is off
		assign led_on[g] = effective_actuate[g] && behaviour_select_i[g];
		// polarity 0 drives low while on, polarity 1 drives high
		assign pin_value[g] = drive_polarity_bit_i[g] ? led_on[g] : !led_on[g];

		always_comb begin
			if (!is_output[g]) begin
				pin_nxt[g] = 1'b0;
				pin_oe_nxt[g] = 1'b0;
			end else if (is_push_pull[g]) begin
				pin_nxt[g] = pin_value[g];
				pin_oe_nxt[g] = 1'b1;
			end else begin
				pin_nxt[g] = 1'b0;
				pin_oe_nxt[g] = !pin_value[g];
			end
		end
	end

	// drive is registered so the pads see no decode glitches
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pin_o <= '0;
			pin_oe_o <= '0;
		end else begin
			pin_o <= pin_nxt;
			pin_oe_o <= pin_oe_nxt;
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	// unmapped offsets read as zero and a read changes no state
	always_comb begin
		case (reg_addr_i)
			OFS_RAMP_DONE_HIGH: rdata_nxt = {5'h00, ramp_done_flag_r};
			OFS_PIN_DIRECTION_SELECT: rdata_nxt = pin_direction_bit_r;
			OFS_PIN_OUTPUT_KIND: rdata_nxt = output_kind_bit_r;
			OFS_PIN_LEVEL_READBACK: rdata_nxt = pin_level_bit_r;
			OFS_LED_ACTUATE_LOW: rdata_nxt = led_actuate_low_r;
			OFS_LED_ACTUATE_HIGH: rdata_nxt = {5'h00, led_actuate_high_r};
			default: rdata_nxt = READ_IDLE;
		endcase
	end

	// valid stands one cycle after every cycle with a read strobe
	always_comb begin
		case (rd_state_r)
			RD_IDLE: rd_state_nxt = reg_rd_i ? RD_HOLD : RD_IDLE;
			RD_HOLD: rd_state_nxt = reg_rd_i ? RD_HOLD : RD_IDLE;
			default: rd_state_nxt = RD_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rd_state_r <= RD_IDLE;
		end else begin
			rd_state_r <= rd_state_nxt;
		end
	end

	// read data holds until the next read strobe
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_r <= READ_IDLE;
		end else if (reg_rd_i) begin
			rdata_r <= rdata_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign reg_rdata_o = rdata_r;
	assign reg_rvalid_o = (rd_state_r == RD_HOLD);
	assign pin_change_flag_o = pin_change_flag_r;
	assign pin_int_o = pin_int_r;
	assign ramp_done_flag_o = ramp_done_flag_r;

endmodule // lgp_top

`default_nettype wire

// ---- tb/lgp_pin_world.sv ----
`default_nettype none

module lgp_pin_world (
	input wire logic [7:0] pin_o_i,
	input wire logic [7:0] pin_oe_i,
	input wire logic [7:0] ext_en_i,
	input wire logic [7:0] ext_lvl_i,
	output logic [7:0] pin_lvl_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// -----------------
	// pull-up per pin
	// -----------------
	// released pins float high; an outside driver only acts where the block lets go
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pin_lvl_o[i] = pin_oe_i[i] ? pin_o_i[i] : (ext_en_i[i] ? ext_lvl_i[i] : 1'b1);
		end
	end
endmodule // lgp_pin_world

`default_nettype wire

// ---- tb/lgp_top_sva.sv ----
`default_nettype none

module lgp_top_sva (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rd_i,
	input wire logic reg_rvalid_o,
	input wire logic [2:0] ramp_finish_i,
	input wire logic int_flag_clear_i,
	input wire logic deep_sleep_request_i,
	input wire logic [2:0] ramp_done_flag_o,
	input wire logic [7:0] pin_change_clear_i,
	input wire logic [7:0] pin_int_enable_i,
	input wire logic [7:0] pin_change_flag_o,
	input wire logic pin_int_o,
	input wire logic [10:0] pin_o,
	input wire logic [10:0] pin_oe_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	rd_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
		else $error("read not answered");
	rd_quiet_a: assert property (!reg_rd_i |=> !reg_rvalid_o)
		else $error("read valid without a read");
	ramp_set_a: assert property (
		(ramp_finish_i != 3'h0) |=> ((ramp_done_flag_o & $past(ramp_finish_i)) == $past(ramp_finish_i)))
		else $error("ramp flag not set");
	ramp_clear_a: assert property (
		(int_flag_clear_i || deep_sleep_request_i) && ramp_finish_i == 3'h0 |=> ramp_done_flag_o == 3'h0)
		else $error("ramp flags not cleared");
	int_follow_a: assert property (
		pin_int_o == |($past(pin_change_flag_o) & $past(pin_int_enable_i)))
		else $error("interrupt does not follow flags");
	flag_sticky_a: assert property (
		(pin_change_flag_o & ~pin_change_clear_i) != 8'h00 |=> (pin_change_flag_o &
		$past(pin_change_flag_o & ~pin_change_clear_i)) == $past(pin_change_flag_o & ~pin_change_clear_i))
		else $error("change flag lost");
	high_od_a: assert property (pin_o[10:8] == 3'h0)
		else $error("high leds not open drain");
	value_needs_oe_a: assert property ((pin_o & ~pin_oe_o) == 11'h000)
		else $error("pin value without enable");
	dir_write_a: assert property (
		reg_wr_i && reg_addr_i == 8'h70 |=> ##1 (pin_oe_o[7:0] & ~$past(reg_wdata_i, 2)) == 8'h00)
		else $error("input pin driven");
endmodule // lgp_top_sva

bind lgp_top lgp_top_sva u_sva (.clk_i, .rst_b_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i,
	.reg_rd_i, .reg_rvalid_o, .ramp_finish_i, .int_flag_clear_i, .deep_sleep_request_i,
	.ramp_done_flag_o, .pin_change_clear_i, .pin_int_enable_i, .pin_change_flag_o,
	.pin_int_o, .pin_o, .pin_oe_o);

`default_nettype wire

// ---- tb/testbench.sv ----
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i, rst_b_i, reg_wr_i, reg_rd_i, reg_rvalid_o, pin_int_o;
	logic group_link_led10_i, group_touch_i, int_flag_clear_i, deep_sleep_request_i;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, pin_change_clear_i, pin_int_enable_i;
	logic [7:0] pin_change_flag_o, pin_i, ext_en, ext_lvl;
	logic [10:0] drive_polarity_bit_i, behaviour_select_i, sensor_link_en_i, sensor_touch_i;
	logic [10:0] pin_o, pin_oe_o;
	logic [2:0] ramp_finish_i, ramp_done_flag_o;
	int error_cnt = 0;
	int num_checks = 0;

	lgp_top DUT (.clk_i, .rst_b_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i,
		.reg_rdata_o, .reg_rvalid_o, .drive_polarity_bit_i, .behaviour_select_i,
		.sensor_link_en_i, .sensor_touch_i, .group_link_led10_i, .group_touch_i,
		.ramp_finish_i, .int_flag_clear_i, .deep_sleep_request_i, .pin_change_clear_i,
		.pin_int_enable_i, .pin_change_flag_o, .pin_int_o, .ramp_done_flag_o, .pin_i,
		.pin_o, .pin_oe_o);
	lgp_pin_world u_world (.pin_o_i(pin_o[7:0]), .pin_oe_i(pin_oe_o[7:0]), .ext_en_i(ext_en),
		.ext_lvl_i(ext_lvl), .pin_lvl_o(pin_i));

	// -----------------
	// helpers
	// -----------------
	task automatic results();
		$display("checks=%0d errors=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [10:0] g, input logic [10:0] e);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		cyc(1);
		reg_wr_i = 1'b0;
		cyc(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		cyc(1);
		reg_rd_i = 1'b0;
		chk({10'h0, reg_rvalid_o}, 11'h001);
		chk({3'h0, reg_rdata_o}, {3'h0, e});
		cyc(1);
	endtask
	// expected drive: on = (actuate or touch) in the on phase, value = pol ? on : !on
	task automatic drv(input logic [7:0] dir, input logic [7:0] ot, input logic [10:0] act,
		input logic [10:0] pl, input logic t, input logic g);
		logic [10:0] on, v, eo, ee;
		wr(8'h70, dir);
		wr(8'h71, ot);
		wr(8'h73, act[7:0]);
		wr(8'h74, {5'h00, act[10:8]});
		drive_polarity_bit_i = pl;
		sensor_touch_i = {11{t}};
		group_link_led10_i = g;
		group_touch_i = g;
		on = (act | (t ? 11'h17F : 11'h000) | (g ? 11'h300 : 11'h000)) & behaviour_select_i;
		v = ~(pl ^ on);
		for (int i = 0; i < 11; i++) begin
			if (i < 8 && !dir[i]) begin
				eo[i] = 1'b0;
				ee[i] = 1'b0;
			end else if (i < 8 && ot[i]) begin
				eo[i] = v[i];
				ee[i] = 1'b1;
			end else begin
				eo[i] = 1'b0;
				ee[i] = ~v[i];
			end
		end
		cyc(3);
		chk(pin_oe_o, ee);
		chk(pin_o, eo);
	endtask

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	initial begin
		#200000;
		error_cnt++;
		results();
	end

	// -----------------
	// tests
	// -----------------
	initial begin
		rst_b_i = 1'b0; reg_wr_i = 1'b0; reg_rd_i = 1'b0; reg_addr_i = 8'h00;
		reg_wdata_i = 8'h00; drive_polarity_bit_i = 11'h000; behaviour_select_i = 11'h7FF;
		sensor_link_en_i = 11'h7FF; sensor_touch_i = 11'h000; group_link_led10_i = 1'b0;
		group_touch_i = 1'b0; ramp_finish_i = 3'h0; int_flag_clear_i = 1'b0;
		deep_sleep_request_i = 1'b0; pin_change_clear_i = 8'h00; pin_int_enable_i = 8'h00;
		ext_en = 8'h00; ext_lvl = 8'h00;
		cyc(20);
		rst_b_i = 1'b1;
		cyc(5);
		rd(8'h70, 8'h00);
		rd(8'h71, 8'h00);
		rd(8'h73, 8'h00);
		rd(8'h74, 8'h00);
		rd(8'h10, 8'h00);
		wr(8'h72, 8'h00);
		rd(8'h72, 8'hFF);
		wr(8'h74, 8'hFF);
		rd(8'h74, 8'h07);
		wr(8'h73, 8'hA5);
		rd(8'h73, 8'hA5);
		drv(8'hFF, 8'h0F, 11'h555, 11'h7FF, 1'b0, 1'b0);
		drv(8'hFF, 8'hF0, 11'h2AA, 11'h000, 1'b0, 1'b0);
		drv(8'hF0, 8'hFF, 11'h7FF, 11'h7FF, 1'b0, 1'b0);
		drv(8'hFF, 8'hFF, 11'h000, 11'h7FF, 1'b1, 1'b0);
		drv(8'hFF, 8'hFF, 11'h000, 11'h7FF, 1'b0, 1'b1);
		behaviour_select_i = 11'h4F0;
		drv(8'hFF, 8'h33, 11'h7FF, 11'h7FF, 1'b0, 1'b0);
		behaviour_select_i = 11'h7FF;
		drv(8'h0F, 8'h0F, 11'h000, 11'h7FF, 1'b0, 1'b0);
		pin_int_enable_i = 8'hFF;
		cyc(5);
		pin_change_clear_i = 8'hFF;
		cyc(2);
		pin_change_clear_i = 8'h00;
		cyc(2);
		rd(8'h72, 8'hF0);
		wr(8'h73, 8'h0F);
		cyc(6);
		chk({3'h0, pin_change_flag_o}, 11'h000);
		rd(8'h72, 8'hFF);
		ext_en = 8'hF0;
		cyc(6);
		chk({3'h0, pin_change_flag_o}, 11'h0F0);
		chk({10'h0, pin_int_o}, 11'h001);
		rd(8'h72, 8'h0F);
		pin_int_enable_i = 8'h00;
		cyc(2);
		chk({10'h0, pin_int_o}, 11'h000);
		ramp_finish_i = 3'h5;
		cyc(1);
		ramp_finish_i = 3'h0;
		cyc(1);
		rd(8'h61, 8'h05);
		int_flag_clear_i = 1'b1;
		cyc(1);
		int_flag_clear_i = 1'b0;
		cyc(1);
		chk({8'h0, ramp_done_flag_o}, 11'h000);
		ramp_finish_i = 3'h2;
		cyc(1);
		ramp_finish_i = 3'h0;
		cyc(1);
		chk({8'h0, ramp_done_flag_o}, 11'h002);
		deep_sleep_request_i = 1'b1;
		cyc(1);
		deep_sleep_request_i = 1'b0;
		cyc(1);
		chk({8'h0, ramp_done_flag_o}, 11'h000);
		results();
	end
endmodule // testbench

`default_nettype wire
